// [rtc_i2c_slave_port.sv]
// Two-wire slave port with register write FIFO
// Summary of operation
// - With the bus idle both lines are high; nobody pulls them low.
// - Data falling while clock high is START; a new transfer begins.
// - Data rising while clock high is STOP; the transfer ends.
// - Transmitter keeps data steady while clock is high.
// - One data bit moves per clock pulse.
// - The port is slave only; it never makes clock, START or STOP.
// - Any number of bytes may pass between START and STOP.
// - Bytes are eight bits, MSB first, then a ninth acknowledge pulse.
// - Addressed and receiving, the port acknowledges every byte, address included.
// - The acknowledger holds data low for the whole acknowledge clock high.
// - After a missing acknowledge the port releases data and stops sending.
// - Address bits 7..1 must match the fixed slave address.
// - Address bit 0 high means read, low means write.
// - On backup battery the port is inactive and ignores the bus.
// - Switching to battery abandons any transfer at once; the port goes idle.
// - Register pointer increments per byte and wraps to zero after last register.
`timescale 1ns/1ns
`default_nettype none
`include "rtcis_defs.svh"

module rtcis_fifo #(
	parameter int WIDTH = `RTCIS_FIFO_WIDTH,
	parameter int DEPTH = `RTCIS_FIFO_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      wp_nxt;
	logic [AW:0]      rp_r;
	logic [AW:0]      rp_nxt;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign empty    = (wp_r == rp_r);
	assign full     = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rp_r[AW-1:0]];
	assign push     = inValid && !full;
	assign pop      = outReady && !empty;

	always_comb
	begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wp_r <= '0;
			rp_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	// Storage carries no reset; only the pointers say what is valid
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wp_r[AW-1:0]] <= inData;
	end
endmodule

module rtc_i2c_slave_port (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                sclIn,
	input  wire logic                sdaIn,
	output logic                     sdaOut,
	output logic                     sdaOe,
	input  wire logic                onBattery,
	output logic                     wrValid,
	input  wire logic                wrReady,
	output rtcis_pkg::rtcis_wr_s     wrData,
	output logic               [6:0] registerPointer,
	input  wire logic          [7:0] rdData
);
	logic [2:0] sclSync_r;
	logic [2:0] sdaSync_r;
	logic [1:0] batSync_r;
	logic       sclS;
	logic       sdaS;
	logic       batS;
	logic       sclRise;
	logic       sclFall;
	logic       startDet;
	logic       stopDet;

	rtcis_pkg::rtcis_state_e st_r;
	rtcis_pkg::rtcis_state_e st_nxt;
	logic [3:0]              cnt_r;
	logic [3:0]              cnt_nxt;
	logic [7:0]              sh_r;
	logic [7:0]              sh_nxt;
	logic                    rw_r;
	logic                    rw_nxt;
	logic                    first_r;
	logic                    first_nxt;
	logic [6:0]              ptr_r;
	logic [6:0]              ptr_nxt;
	logic [6:0]              ptrInc;
	logic                    oe_r;
	logic                    oe_nxt;
	logic                    pend_r;
	logic                    pend_nxt;
	rtcis_pkg::rtcis_wr_s    pdat_r;
	rtcis_pkg::rtcis_wr_s    pdat_nxt;
	logic                    fifoInReady;
	logic [`RTCIS_FIFO_WIDTH-1:0] fifoOut;

	// Pins are asynchronous to sys_clk; stage 2 is the synced value, stage 3 its history
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			sclSync_r <= 3'h7;
			sdaSync_r <= 3'h7;
			batSync_r <= 2'h0;
		end
		else
		begin
			sclSync_r <= {sclSync_r[1:0], sclIn};
			sdaSync_r <= {sdaSync_r[1:0], sdaIn};
			batSync_r <= {batSync_r[0], onBattery};
		end
	end

	assign sclS     = sclSync_r[1];
	assign sdaS     = sdaSync_r[1];
	assign batS     = batSync_r[1];
	assign sclRise  = sclS && !sclSync_r[2];
	assign sclFall  = !sclS && sclSync_r[2];
	assign startDet = sclS && sclSync_r[2] && sdaSync_r[2] && !sdaS;
	assign stopDet  = sclS && sclSync_r[2] && !sdaSync_r[2] && sdaS;
	assign ptrInc   = (ptr_r == `RTCIS_LAST_REG) ? 7'h00 : ptr_r + 7'h01;

	always_comb
	begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		rw_nxt    = rw_r;
		first_nxt = first_r;
		ptr_nxt   = ptr_r;
		oe_nxt    = oe_r;
		pend_nxt  = pend_r;
		pdat_nxt  = pdat_r;
		if (pend_r && fifoInReady)
			pend_nxt = 1'b0;
		if (batS)
		begin
			st_nxt = rtcis_pkg::ST_IDLE;
			oe_nxt = 1'b0;
		end
		else if (startDet)
		begin
			st_nxt  = rtcis_pkg::ST_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt  = 1'b0;
		end
		else if (stopDet)
		begin
			st_nxt = rtcis_pkg::ST_IDLE;
			oe_nxt = 1'b0;
		end
		else
		begin
			case (st_r)
				rtcis_pkg::ST_ADDR, rtcis_pkg::ST_RX:
				begin
					if (sclRise && cnt_r < `RTCIS_BYTE_BITS)
					begin
						sh_nxt  = {sh_r[6:0], sdaS};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (sclFall && cnt_r == `RTCIS_BYTE_BITS)
					begin
						if (st_r == rtcis_pkg::ST_ADDR)
						begin
							if (sh_r[7:1] == `RTCIS_SLAVE_ADDR)
							begin
								st_nxt    = rtcis_pkg::ST_ACK;
								oe_nxt    = 1'b1;
								rw_nxt    = sh_r[0];
								first_nxt = 1'b1;
							end
							else
								st_nxt = rtcis_pkg::ST_IGNORE;
						end
						else
						begin
							st_nxt    = rtcis_pkg::ST_ACK;
							oe_nxt    = 1'b1;
							first_nxt = 1'b0;
							if (first_r)
								ptr_nxt = sh_r[6:0];
							else
							begin
								// A byte still waiting on a full FIFO is overwritten
								pend_nxt = 1'b1;
								pdat_nxt = '{regAddr: ptr_r, regData: sh_r};
								ptr_nxt  = ptrInc;
							end
						end
					end
				end
				rtcis_pkg::ST_ACK:
				begin
					// Release only on the falling edge so data stays low all of clock high
					if (sclFall)
					begin
						cnt_nxt = 4'h0;
						if (rw_r)
						begin
							st_nxt = rtcis_pkg::ST_TX;
							sh_nxt = rdData;
							oe_nxt = !rdData[7];
						end
						else
						begin
							st_nxt = rtcis_pkg::ST_RX;
							oe_nxt = 1'b0;
						end
					end
				end
				rtcis_pkg::ST_TX:
				begin
					if (sclFall && cnt_r == 4'h7)
					begin
						cnt_nxt = `RTCIS_BYTE_BITS;
						oe_nxt  = 1'b0; // Master drives the acknowledge
					end
					else if (sclFall && cnt_r < 4'h7)
					begin
						cnt_nxt = cnt_r + 4'h1;
						sh_nxt  = {sh_r[6:0], 1'b0};
						oe_nxt  = !sh_r[6];
					end
					else if (sclRise && cnt_r == `RTCIS_BYTE_BITS)
					begin
						ptr_nxt = ptrInc;
						if (sdaS)
							st_nxt = rtcis_pkg::ST_IGNORE;
						else
							cnt_nxt = `RTCIS_ACKED_MARK;
					end
					else if (sclFall && cnt_r == `RTCIS_ACKED_MARK)
					begin
						cnt_nxt = 4'h0;
						sh_nxt  = rdData;
						oe_nxt  = !rdData[7];
					end
				end
				rtcis_pkg::ST_IDLE, rtcis_pkg::ST_IGNORE:
					oe_nxt = 1'b0;
				default:
				begin
					st_nxt = rtcis_pkg::ST_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_r    <= rtcis_pkg::ST_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			rw_r    <= 1'b0;
			first_r <= 1'b0;
			ptr_r   <= 7'h00;
			oe_r    <= 1'b0;
			pend_r  <= 1'b0;
			pdat_r  <= '0;
		end
		else
		begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			rw_r    <= rw_nxt;
			first_r <= first_nxt;
			ptr_r   <= ptr_nxt;
			oe_r    <= oe_nxt;
			pend_r  <= pend_nxt;
			pdat_r  <= pdat_nxt;
		end
	end

	// Open-drain: only ever pull low
	assign sdaOut          = 1'b0;
	assign sdaOe           = oe_r;
	assign registerPointer = ptr_r;
	assign wrData          = rtcis_pkg::rtcis_wr_s'(fifoOut);

	rtcis_fifo #(
		.WIDTH(`RTCIS_FIFO_WIDTH),
		.DEPTH(`RTCIS_FIFO_DEPTH)
	) wrFifo (
		.sys_clk (sys_clk),
		.rst     (rst),
		.inValid (pend_r),
		.inReady (fifoInReady),
		.inData  (pdat_r),
		.outValid(wrValid),
		.outReady(wrReady),
		.outData (fifoOut)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_idle_released: assert property (st_r == rtcis_pkg::ST_IDLE |-> !sdaOe)
		else $error("data driven while idle");
	a_start_addr: assert property (startDet && !batS |=> st_r == rtcis_pkg::ST_ADDR)
		else $error("start not taken");
	a_stop_idle: assert property (stopDet && !batS |=> st_r == rtcis_pkg::ST_IDLE)
		else $error("stop not taken");
	a_oe_on_fall: assert property ($changed(sdaOe) |-> $past(sclFall || startDet || stopDet || batS))
		else $error("data changed outside clock low");
	a_ack_hold: assert property (st_r == rtcis_pkg::ST_ACK && sclRise |-> sdaOe [*2])
		else $error("acknowledge not held");
	a_nack_release: assert property (st_r == rtcis_pkg::ST_TX && cnt_r == 4'h8 && sclRise && sdaS && !batS && !startDet && !stopDet |=> st_r == rtcis_pkg::ST_IGNORE && !sdaOe)
		else $error("no release after missing acknowledge");
	a_mismatch_quiet: assert property (st_r == rtcis_pkg::ST_IGNORE |-> !sdaOe)
		else $error("driven while not addressed");
	a_battery_quiet: assert property (batS |=> st_r == rtcis_pkg::ST_IDLE && !sdaOe)
		else $error("active on battery");
	a_ptr_wrap: assert property (ptr_r == `RTCIS_LAST_REG && ptr_nxt != ptr_r && st_r == rtcis_pkg::ST_TX |=> ptr_r == 7'h00)
		else $error("pointer did not wrap");
	a_bit_count: assert property (cnt_r <= `RTCIS_ACKED_MARK)
		else $error("bit count out of range");

	c_write_byte: cover property (pend_r && fifoInReady);
	c_read_nack: cover property (st_r == rtcis_pkg::ST_TX ##1 st_r == rtcis_pkg::ST_IGNORE);
	c_mismatch: cover property (st_r == rtcis_pkg::ST_ADDR ##1 st_r == rtcis_pkg::ST_IGNORE);
endmodule
`default_nettype wire

// [rtcis_defs.svh]
// Constants for the real-time clock two-wire slave port
`ifndef RTCIS_DEFS_SVH
`define RTCIS_DEFS_SVH
`define RTCIS_SLAVE_ADDR 7'h53
`define RTCIS_LAST_REG   7'h36
`define RTCIS_BYTE_BITS  4'h8
`define RTCIS_ACKED_MARK 4'h9
`define RTCIS_FIFO_DEPTH 32'h10
`define RTCIS_FIFO_WIDTH 32'hF
`endif

// [rtcis_pkg.sv]
// Types shared by the real-time clock two-wire slave port
`default_nettype none
package rtcis_pkg;
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_ADDR   = 6'h02,
		ST_RX     = 6'h04,
		ST_ACK    = 6'h08,
		ST_TX     = 6'h10,
		ST_IGNORE = 6'h20
	} rtcis_state_e;
	typedef struct packed {
		logic [6:0] regAddr;
		logic [7:0] regData;
	} rtcis_wr_s;
endpackage
`default_nettype wire

// [rtcis_master.sv]
// Bus master model that drives the two-wire link toward the slave port
`timescale 1ns/1ns
`default_nettype none
module rtcis_master (
	input  wire logic sdaWire,
	output logic      sclLine,
	output logic      sdaPull
);
	initial
	begin
		sclLine = 1'b1;
		sdaPull = 1'b0;
	end

	// Data changes only mid low phase and holds through the high phase
	// Seen is unknown if the line differs between the samples taken 20 and 42 ns into clock high
	task automatic bitCycle(input logic v, output logic seen);
		logic s1;
		#31 sdaPull = ~v;
		#32 sclLine = 1'b1;
		#20 s1 = sdaWire;
		#22 seen = (s1 === sdaWire) ? s1 : 1'bx;
		#20 sclLine = 1'b0;
	endtask

	// Called only with the bus idle or at the end of a byte
	task automatic busStart();
		if (sclLine === 1'b0)
		begin
			#31 sdaPull = 1'b0;
			#32 sclLine = 1'b1;
		end
		#31 sdaPull = 1'b1;
		#31 sclLine = 1'b0;
	endtask

	task automatic busStop();
		#31 sdaPull = 1'b1;
		#32 sclLine = 1'b1;
		#31 sdaPull = 1'b0;
		#62;
	endtask

	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitCycle(b[i], s);
		bitCycle(1'b1, ack);
	endtask

	// Acks every byte but the last; leaving the line high ends the read
	task automatic recvByte(input logic giveAck, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitCycle(1'b1, b[i]);
		bitCycle(~giveAck, s);
	endtask
endmodule
`default_nettype wire

// [rtc_i2c_slave_port_tb.sv]
// Self-checking bench for the two-wire slave port
`timescale 1ns/1ns
`default_nettype none
module rtc_i2c_slave_port_tb;
	logic                 sys_clk;
	logic                 rst;
	logic                 onBattery;
	logic                 wrReady;
	logic                 sdaOut;
	logic                 sdaOe;
	logic                 wrValid;
	rtcis_pkg::rtcis_wr_s wrData;
	logic           [6:0] registerPointer;
	logic           [7:0] rdData;
	logic                 sclLine;
	logic                 sdaPull;
	wire logic            sdaWire;
	int                   failures;
	int                   checkCount;

	// Open drain: a released line sits high through the pull-up
	assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;
	// Register file stand-in: a fixed pattern of the pointer
	assign rdData = {registerPointer, 1'b0} ^ 8'h5A;

	rtc_i2c_slave_port i_dut (
		.sys_clk(sys_clk), .rst(rst), .sclIn(sclLine), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .onBattery(onBattery), .wrValid(wrValid),
		.wrReady(wrReady), .wrData(wrData), .registerPointer(registerPointer),
		.rdData(rdData)
	);

	rtcis_master i_master (.sdaWire(sdaWire), .sclLine(sclLine), .sdaPull(sdaPull));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checkCount++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic popExpect(input logic [6:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (wrValid !== 1'b1 && n < 40)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 40)
		begin
			failures++;
			stop_test();
		end
		check("wrData", {1'b0, a, d}, {1'b0, wrData});
		@(posedge sys_clk);
		wrReady <= 1'b1;
		@(posedge sys_clk);
		wrReady <= 1'b0;
		#1;
	endtask

	// Seventeen bytes into a stalled sink: sixteen queue, one waits; pointer wraps
	task automatic writeBurst();
		logic       ack;
		logic [6:0] p;
		i_master.busStart();
		i_master.sendByte(8'hA6, ack);
		check("addr ack", 0, ack);
		i_master.sendByte(8'h30, ack);
		check("ptr ack", 0, ack);
		for (int i = 0; i < 17; i++)
		begin
			i_master.sendByte(8'h40 + i[7:0], ack);
			check("data ack", 0, ack);
		end
		i_master.busStop();
		p = 7'h30;
		for (int i = 0; i < 17; i++)
		begin
			popExpect(p, 8'h40 + i[7:0]);
			p = (p == 7'h36) ? 7'h00 : p + 7'h01;
		end
		check("fifo empty", 0, wrValid);
		check("write pointer", p, registerPointer);
	endtask

	// Pointer load, repeated START, read across the wrap, NACK on the last byte
	task automatic readWrap();
		logic       ack;
		logic [7:0] b;
		logic [6:0] p;
		i_master.busStart();
		i_master.sendByte(8'hA6, ack);
		i_master.sendByte(8'h35, ack);
		i_master.busStart();
		i_master.sendByte(8'hA7, ack);
		check("read addr ack", 0, ack);
		p = 7'h35;
		for (int i = 0; i < 3; i++)
		begin
			i_master.recvByte(i < 2, b);
			check("read data", {p, 1'b0} ^ 8'h5A, b);
			p = (p == 7'h36) ? 7'h00 : p + 7'h01;
		end
		#40;
		check("release after nack", 0, sdaOe);
		i_master.busStop();
		check("read pointer", p, registerPointer);
		check("read no write", 0, wrValid);
	endtask

	// Foreign addresses are never acknowledged, nor is anything after them
	task automatic foreignAddr();
		logic       ack;
		logic [7:0] bad [3];
		bad = '{8'hA4, 8'hE6, 8'hA8};
		foreach (bad[i])
		begin
			i_master.busStart();
			i_master.sendByte(bad[i], ack);
			check("foreign ack", 1, ack);
			i_master.sendByte(8'h00, ack);
			check("foreign data", 1, ack);
			i_master.busStop();
		end
		check("foreign write", 0, wrValid);
	endtask

	// Supply drops mid-transfer; STOP then START brings the port back
	task automatic batteryCut();
		logic ack;
		i_master.busStart();
		i_master.sendByte(8'hA6, ack);
		check("pre cut ack", 0, ack);
		@(posedge sys_clk);
		onBattery <= 1'b1;
		repeat (5) @(posedge sys_clk);
		i_master.sendByte(8'h12, ack);
		check("battery ack", 1, ack);
		@(posedge sys_clk);
		onBattery <= 1'b0;
		repeat (5) @(posedge sys_clk);
		i_master.busStop();
		i_master.busStart();
		i_master.sendByte(8'hA6, ack);
		check("revived ack", 0, ack);
		i_master.busStop();
		check("battery write", 0, wrValid);
		// Bus is idle here, so this switch-over cuts no transfer
		@(posedge sys_clk);
		onBattery <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		check("battery idle", 0, sdaOe);
		@(posedge sys_clk);
		onBattery <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	initial
	begin
		rst = 1'b1;
		onBattery = 1'b0;
		wrReady = 1'b0;
		failures = 0;
		checkCount = 0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		check("idle sda", 0, sdaOe);
		check("sda drive level", 0, sdaOut);
		writeBurst();
		readWrap();
		foreignAddr();
		batteryCut();
		stop_test();
	end
endmodule
`default_nettype wire
